// ==== hw/tcf_timer.sv ====
// Module: timer control register, overflow flags, reload/capture and interrupt request
`timescale 1ns/1ps
`default_nettype none
module tcf_timer
   import tcf_pkg::*;
(
   input  wire logic          i_sys_clk,
   input  wire logic          i_reset,
   input  wire tcf_sfr_req_t  i_sfr,
   output logic [7:0]         o_sfr_rdata,
   input  wire logic          i_timer_irq_enable,
   input  wire logic          i_high_system_clock_sel,
   input  wire logic          i_low_system_clock_sel,
   input  wire logic          i_ext_osc_div8,
   input  wire logic          i_rtc_clock,
   output logic               o_irq
);
   tcf_control_t ctl;
   logic [7:0]   count_low_byte;
   logic [7:0]   count_high_byte;
   logic [7:0]   reload_low_byte;
   logic [7:0]   reload_high_byte;
   logic [3:0]   div12;
   logic         tick12;
   logic         ext_rise;
   logic         rtc_rise;
   logic         aux_tick;
   logic         capture_trig;
   logic         tick_low;
   logic         tick_high;
   logic         run_low;
   logic         run_high;
   logic         low_wrap;
   logic         high_wrap;
   logic         capture_evt;
   logic         page_hit;
   logic         wr_ctl;

   ////////////////////////////////////////////////////////////////////////////
   // Clock sources
   tcf_sync u_ext_sync (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_async   (i_ext_osc_div8),
      .o_rise    (ext_rise)
   );

   tcf_sync u_rtc_sync (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_async   (i_rtc_clock),
      .o_rise    (rtc_rise)
   );

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         div12 <= 4'h0;
      end else if (div12 == DIV12_LAST) begin
         div12 <= 4'h0;
      end else begin
         div12 <= div12 + 4'h1;
      end
   end
   assign tick12 = (div12 == DIV12_LAST);

   always_comb begin
      case (ctl.aux_clock_select)
         XCLK_DIV12: begin
            aux_tick     = tick12;
            capture_trig = rtc_rise;
         end
         XCLK_EXT8: begin
            aux_tick     = ext_rise;
            capture_trig = ext_rise;
         end
         XCLK_RTC: begin
            aux_tick     = rtc_rise;
            capture_trig = ext_rise;
         end
         default: begin
            aux_tick     = 1'b0;
            capture_trig = 1'b0;
         end
      endcase
   end

   assign tick_low  = i_low_system_clock_sel  ? 1'b1 : aux_tick;
   assign tick_high = i_high_system_clock_sel ? 1'b1 : aux_tick;

   ////////////////////////////////////////////////////////////////////////////
   // Counter datapath
   // run gating
   assign run_low  = ctl.split_mode_enable ? tick_low : (ctl.run_control && tick_low);
   assign run_high = ctl.split_mode_enable ? (ctl.run_control && tick_high) : 1'b0;

   assign low_wrap    = run_low && (count_low_byte == BYTE_MAX);
   assign high_wrap   = ctl.split_mode_enable ? (run_high && (count_high_byte == BYTE_MAX))
                                              : (low_wrap && (count_high_byte == BYTE_MAX));
   assign capture_evt = ctl.capture_enable && capture_trig;

   assign page_hit = (i_sfr.page == SFR_PAGE_TIMER);
   assign wr_ctl   = i_sfr.wr && page_hit && (i_sfr.addr == ADDR_CONTROL);

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         count_low_byte <= 8'h00;
      end else if (i_sfr.wr && page_hit && i_sfr.addr == ADDR_COUNT_LOW) begin
         count_low_byte <= i_sfr.wdata;
      // unsplit low reload on full wrap only
      end else if (low_wrap && !ctl.capture_enable && (ctl.split_mode_enable || high_wrap)) begin
         count_low_byte <= reload_low_byte;
      end else if (run_low) begin
         count_low_byte <= count_low_byte + 8'h01;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         count_high_byte <= 8'h00;
      end else if (i_sfr.wr && page_hit && i_sfr.addr == ADDR_COUNT_HIGH) begin
         count_high_byte <= i_sfr.wdata;
      end else if (high_wrap && !ctl.capture_enable) begin
         count_high_byte <= reload_high_byte;
      end else if (ctl.split_mode_enable ? run_high : low_wrap) begin
         count_high_byte <= count_high_byte + 8'h01;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         reload_low_byte  <= 8'h00;
         reload_high_byte <= 8'h00;
      end else if (capture_evt) begin
         reload_low_byte  <= count_low_byte;
         reload_high_byte <= count_high_byte;
      end else begin
         if (i_sfr.wr && page_hit && i_sfr.addr == ADDR_RELOAD_LOW) begin
            reload_low_byte <= i_sfr.wdata;
         end
         if (i_sfr.wr && page_hit && i_sfr.addr == ADDR_RELOAD_HIGH) begin
            reload_high_byte <= i_sfr.wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control register
   // decode and reset
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         ctl <= tcf_control_t'(CONTROL_RESET);
      end else begin
         if (wr_ctl) begin
            ctl <= tcf_control_t'(i_sfr.wdata);
         end
         if (high_wrap || capture_evt) begin
            ctl.high_overflow_flag <= 1'b1;
         end
         if (low_wrap) begin
            ctl.low_overflow_flag <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_sfr_rdata <= 8'h00;
      end else if (i_sfr.rd && page_hit) begin
         case (i_sfr.addr)
            ADDR_CONTROL:     o_sfr_rdata <= ctl;
            ADDR_RELOAD_LOW:  o_sfr_rdata <= reload_low_byte;
            ADDR_RELOAD_HIGH: o_sfr_rdata <= reload_high_byte;
            ADDR_COUNT_LOW:   o_sfr_rdata <= count_low_byte;
            ADDR_COUNT_HIGH:  o_sfr_rdata <= count_high_byte;
            default:          o_sfr_rdata <= 8'h00;
         endcase
      end
   end

   assign o_irq = i_timer_irq_enable &&
                  (ctl.high_overflow_flag || (ctl.low_byte_irq_enable && ctl.low_overflow_flag));

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_full_wrap;
      !ctl.split_mode_enable && low_wrap && count_high_byte == BYTE_MAX;
   endsequence

   a_high_flag_sets: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      high_wrap |=> ctl.high_overflow_flag) else $error("high flag missed");
   a_full_wrap_reload: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      s_full_wrap ##0 !ctl.capture_enable && !i_sfr.wr |=>
      ctl.high_overflow_flag && count_high_byte == $past(reload_high_byte)
      && count_low_byte == $past(reload_low_byte)) else $error("wrap reload wrong");
   a_irq_high: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      high_wrap || capture_evt |=> o_irq || !i_timer_irq_enable) else $error("irq missing");
   a_flag_sticky: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      ctl.high_overflow_flag && !wr_ctl |=> ctl.high_overflow_flag) else $error("flag self-cleared");
   a_low_flag_sets: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      low_wrap |=> ctl.low_overflow_flag) else $error("low flag missed");
   a_irq_low: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      low_wrap && !wr_ctl && ctl.low_byte_irq_enable |=> o_irq || !i_timer_irq_enable)
      else $error("low irq missing");
   a_split_run: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      ctl.split_mode_enable && !ctl.run_control && !i_sfr.wr |=> $stable(count_high_byte))
      else $error("high byte ran while stopped");
   a_capture_copy: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      capture_evt |=> reload_low_byte == $past(count_low_byte) && ctl.high_overflow_flag)
      else $error("capture copy wrong");
   a_set_wins: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      wr_ctl && !i_sfr.wdata[BIT_LOW_FLAG] && low_wrap |=> ctl.low_overflow_flag)
      else $error("clear beat set");
endmodule
`default_nettype wire

// ==== hw/tcf_pkg.sv ====
// Package: register map, field positions and timing constants of the timer control block
package tcf_pkg;
   localparam logic [3:0] SFR_PAGE_TIMER   = 4'h0;
   localparam logic [7:0] ADDR_CONTROL     = 8'h91;
   localparam logic [7:0] ADDR_RELOAD_LOW  = 8'h92;
   localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
   localparam logic [7:0] ADDR_COUNT_LOW   = 8'h94;
   localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h95;
   localparam logic [7:0] CONTROL_RESET    = 8'h00;
   localparam int BIT_HIGH_FLAG  = 7;
   localparam int BIT_LOW_FLAG   = 6;
   localparam int BIT_LOW_IRQ_EN = 5;
   localparam int BIT_CAPTURE_EN = 4;
   localparam int BIT_SPLIT      = 3;
   localparam int BIT_RUN        = 2;
   localparam logic [1:0] XCLK_DIV12  = 2'h0;
   localparam logic [1:0] XCLK_EXT8   = 2'h1;
   localparam logic [1:0] XCLK_RTC    = 2'h3;
   localparam logic [3:0] DIV12_LAST  = 4'hB;
   localparam logic [7:0] BYTE_MAX    = 8'hFF;

   typedef struct packed {
      logic       high_overflow_flag;
      logic       low_overflow_flag;
      logic       low_byte_irq_enable;
      logic       capture_enable;
      logic       split_mode_enable;
      logic       run_control;
      logic [1:0] aux_clock_select;
   } tcf_control_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] page;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tcf_sfr_req_t;
endpackage

// ==== hw/tcf_sync.sv ====
// Module: three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module tcf_sync
   import tcf_pkg::*;
(
   input  wire logic i_sys_clk,
   input  wire logic i_reset,
   input  wire logic i_async,
   output logic      o_rise
);
   logic s1;
   logic s2;
   logic s3;
   logic level;

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= i_async;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Level changes only once two late stages agree
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         level <= 1'b0;
      end else if (s2 == s3) begin
         level <= s3;
      end
   end

   assign o_rise = (s2 == s3) && s3 && !level;
endmodule
`default_nettype wire

// ==== test/tb_tcf_timer.sv ====
// Testbench: control register, flags, split mode, capture and interrupt request
`timescale 1ns/1ps
`default_nettype none
module tb_tcf_timer
   import tcf_pkg::*;
;
   logic         clk;
   logic         rst;
   tcf_sfr_req_t sfr;
   logic [7:0]   rdata;
   logic         irq_en;
   logic         hsel;
   logic         lsel;
   logic         ext;
   logic         rtc;
   logic         irq;
   int           miscompares;
   int           comparisons;

   tcf_timer tcf_timer_inst (
      .i_sys_clk          (clk),
      .i_reset            (rst),
      .i_sfr              (sfr),
      .o_sfr_rdata        (rdata),
      .i_timer_irq_enable (irq_en),
      .i_high_system_clock_sel  (hsel),
      .i_low_system_clock_sel   (lsel),
      .i_ext_osc_div8     (ext),
      .i_rtc_clock        (rtc),
      .o_irq              (irq)
   );

   always #20 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr(input logic [3:0] page, input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk);
      #1 sfr <= '{1'b1, 1'b0, page, addr, data};
      @(posedge clk);
      #1 sfr.wr <= 1'b0;
   endtask

   task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp, input string what);
      @(posedge clk);
      #1 sfr <= '{1'b0, 1'b1, SFR_PAGE_TIMER, addr, 8'h00};
      @(posedge clk);
      #1 sfr.rd <= 1'b0;
      @(posedge clk);
      #1 check(rdata, exp, what);
   endtask

   // Edge on one aux pin, long enough for the synchroniser
   task automatic pulse(input logic use_rtc);
      @(posedge clk);
      #1 {rtc, ext} <= {use_rtc, ~use_rtc};
      cycles(4);
      #1 {rtc, ext} <= 2'b00;
      cycles(8);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_reset();
      rd_check(ADDR_CONTROL, CONTROL_RESET, "control reset");
      rd_check(8'h90, 8'h00, "unmapped read");
      wr(4'h1, ADDR_CONTROL, 8'hFF);
      rd_check(ADDR_CONTROL, 8'h00, "other page write");
      wr(SFR_PAGE_TIMER, ADDR_CONTROL, 8'h3B);
      rd_check(ADDR_CONTROL, 8'h3B, "control readback");
      wr(SFR_PAGE_TIMER, ADDR_CONTROL, 8'h00);
      $display("test_reset done");
   endtask

   task automatic test_wide();
      {hsel, lsel, irq_en} = 3'b111;
      wr(SFR_PAGE_TIMER, ADDR_RELOAD_LOW, 8'h34);
      wr(SFR_PAGE_TIMER, ADDR_RELOAD_HIGH, 8'h12);
      wr(SFR_PAGE_TIMER, ADDR_COUNT_LOW, 8'hFE);
      wr(SFR_PAGE_TIMER, ADDR_COUNT_HIGH, 8'hFF);
      wr(SFR_PAGE_TIMER, ADDR_CONTROL, 8'h04);
      cycles(10);
      rd_check(ADDR_CONTROL, 8'hC4, "wrap flags");
      check({7'h00, irq}, 8'h01, "irq on high flag");
      irq_en <= 1'b0;
      @(posedge clk);
      #1 check({7'h00, irq}, 8'h00, "irq masked");
      irq_en <= 1'b1;
      cycles(20);
      rd_check(ADDR_CONTROL, 8'hC4, "flags held");
      wr(SFR_PAGE_TIMER, ADDR_CONTROL, 8'h00);
      rd_check(ADDR_CONTROL, 8'h00, "flags cleared");
      check({7'h00, irq}, 8'h00, "irq after clear");
      rd_check(ADDR_COUNT_HIGH, 8'h12, "reloaded high byte");
      wr(SFR_PAGE_TIMER, ADDR_COUNT_LOW, 8'hFE);
      wr(SFR_PAGE_TIMER, ADDR_COUNT_HIGH, 8'h00);
      wr(SFR_PAGE_TIMER, ADDR_CONTROL, 8'h04);
      wr(SFR_PAGE_TIMER, ADDR_CONTROL, 8'h00);
      rd_check(ADDR_CONTROL, 8'h40, "set beats clear");
      rd_check(ADDR_COUNT_LOW, 8'h00, "low carry no reload");
      rd_check(ADDR_COUNT_HIGH, 8'h01, "high carry");
      wr(SFR_PAGE_TIMER, ADDR_CONTROL, 8'h00);
      $display("test_wide done");
   endtask

   task automatic test_split();
      wr(SFR_PAGE_TIMER, ADDR_COUNT_LOW, 8'hFD);
      wr(SFR_PAGE_TIMER, ADDR_COUNT_HIGH, 8'hFF);
      wr(SFR_PAGE_TIMER, ADDR_CONTROL, 8'h08);
      cycles(8);
      rd_check(ADDR_CONTROL, 8'h48, "low flag only");
      check({7'h00, irq}, 8'h00, "low irq disabled");
      rd_check(ADDR_COUNT_HIGH, 8'hFF, "high byte stopped");
      wr(SFR_PAGE_TIMER, ADDR_CONTROL, 8'h28);
      wr(SFR_PAGE_TIMER, ADDR_COUNT_LOW, 8'hFE);
      cycles(8);
      rd_check(ADDR_CONTROL, 8'h68, "low flag again");
      check({7'h00, irq}, 8'h01, "low irq enabled");
      wr(SFR_PAGE_TIMER, ADDR_CONTROL, 8'h2C);
      cycles(8);
      rd_check(ADDR_CONTROL, 8'hAC, "high byte wrap");
      @(posedge clk);
      #1 rst <= 1'b1;
      cycles(2);
      #1 rst <= 1'b0;
      rd_check(ADDR_CONTROL, 8'h00, "mid-run reset");
      check({7'h00, irq}, 8'h00, "irq after reset");
      $display("test_split done");
   endtask

   task automatic test_capture();
      logic [1:0] codes [3] = '{XCLK_DIV12, XCLK_EXT8, XCLK_RTC};
      logic       trig_rtc [3] = '{1'b1, 1'b0, 1'b0};
      logic [7:0] v;
      {hsel, lsel} = 2'b00;
      for (int i = 0; i < 3; i++) begin
         v = 8'h51 + 8'(i);
         wr(SFR_PAGE_TIMER, ADDR_RELOAD_LOW, 8'h00);
         wr(SFR_PAGE_TIMER, ADDR_RELOAD_HIGH, 8'h00);
         wr(SFR_PAGE_TIMER, ADDR_COUNT_LOW, v);
         wr(SFR_PAGE_TIMER, ADDR_COUNT_HIGH, 8'hA5);
         wr(SFR_PAGE_TIMER, ADDR_CONTROL, {6'b000100, codes[i]});
         pulse(~trig_rtc[i]);
         rd_check(ADDR_CONTROL, {6'b000100, codes[i]}, "wrong trigger");
         pulse(trig_rtc[i]);
         rd_check(ADDR_CONTROL, {6'b100100, codes[i]}, "capture flag");
         check({7'h00, irq}, 8'h01, "capture irq");
         rd_check(ADDR_RELOAD_LOW, v, "captured low");
         rd_check(ADDR_RELOAD_HIGH, 8'hA5, "captured high");
      end
      wr(SFR_PAGE_TIMER, ADDR_CONTROL, 8'h01);
      pulse(1'b0);
      rd_check(ADDR_CONTROL, 8'h01, "capture off");
      wr(SFR_PAGE_TIMER, ADDR_COUNT_LOW, 8'h00);
      wr(SFR_PAGE_TIMER, ADDR_CONTROL, 8'h05);
      pulse(1'b0);
      pulse(1'b1);
      rd_check(ADDR_COUNT_LOW, 8'h01, "ext clock tick");
      $display("test_capture done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #4000000;
      miscompares++;
      stop_test();
   end

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      sfr = '0;
      {irq_en, hsel, lsel, ext, rtc} = 5'b00000;
      miscompares = 0;
      comparisons = 0;
      cycles(3);
      #1 rst <= 1'b0;
      test_reset();
      test_wide();
      test_split();
      test_capture();
      stop_test();
   end
endmodule
`default_nettype wire
